// *** rtl/heater_job.v ***
// Job interpreter of a multi-channel heater controller behind a fieldbus
// master: output buffer in, acknowledgment/startup frame out.
// Assumes master writes the buffer, then commits; inputs are synchronous.
//
// Summary of operation
// - Group assignment comes first; complete when block number equals count.
// - At most sixteen groups; a further group gives error 11.
// - Channel output is basic percent times group override percent.
// - No group checked after init; command 1 checks, 0 not, else 8.
// - Jobs 02 to 04 before assignment complete give error 2.
// - Startup frame after start, communication loss and master stop.
// - Startup byte 1 holds 50, 60 or 0 for mains frequency.
// - Startup bytes 2-3: bit per slot, 0 present, bits 12-15 one.
// - Slot n holds channels 16(n-1)+1 to 16n, twelve slots.
// - New output data is processed, then acknowledged in input buffer.
// - Input and output areas each change as one consistent unit.
// - Job type above 04 gives error 3; length above 28 gives 4.
// - Group outside 1-16 gives 5; channel outside 1-192 gives 6.
// - Override above 100 gives 9; basic value above 100 gives 10.
// - Unassigned channel gives 12; unparameterised group gives 13.
// - Channel list clash gives 14; storage shortfall gives 1 (the code never raises error 1).
// - Job codes 00 none, 01-04 jobs, 05 module report.
// - A failed job sets the fail bit and puts error in byte 2.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "heater_job_map.vh"
module heater_job #(
   parameter [4:0] MAX_GROUPS = 5'h10
) (
   input  wire        I_CLK_SYS,
   input  wire        I_SRST,
   input  wire [5:0]  I_ADDR,
   input  wire [7:0]  I_WDATA,
   input  wire        I_WR,
   input  wire        I_RD,
   output reg  [7:0]  O_RDATA,
   input  wire [7:0]  I_LINE_FREQ,
   input  wire [11:0] I_SLOT_PRESENT,
   input  wire        I_COMM_LOST,
   input  wire        I_MASTER_STOP,
   output reg         O_ASSIGN_DONE,
   output wire        O_CHAN_VALID,
   output wire [7:0]  O_CHAN_NUM,
   output wire [6:0]  O_CHAN_POWER,
   output wire        O_CHAN_CHECK
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_HDR  = 3'd1;
   localparam [2:0] ST_ENT  = 3'd2;
   localparam [2:0] ST_FILL = 3'd3;
   localparam [2:0] ST_ACK  = 3'd4;

   reg  [7:0] stage    [0:31];
   reg  [7:0] work     [0:31];
   reg  [7:0] inbuf    [0:3];
   reg  [4:0] chan_grp [0:`CHAN_COUNT-1];
   reg  [6:0] base     [0:`CHAN_COUNT-1];
   reg  [6:0] ovr      [0:`GROUP_COUNT-1];
   reg [15:0] grp_def;
   reg [15:0] test_on;
   reg  [4:0] grp_cnt;
   reg        dirty;
   reg        start_req;
   reg        link_prev;
   reg  [2:0] state;
   reg  [7:0] err;
   reg  [4:0] ptr;
   reg  [3:0] ent_left;
   reg  [7:0] fill_ch;
   reg  [7:0] fill_end;
   reg  [1:0] fill_step;
   reg  [4:0] fill_grp;
   reg  [7:0] scan;
   integer    k;
   integer    j;
   integer    n;

   // Group 1..16 and channel 1..192 range checks, used by several jobs
   function grp_ok;
      input [7:0] g;
      grp_ok = (g != 8'h00) && (g <= `MAX_GROUP);
   endfunction

   function chan_ok;
      input [7:0] c;
      chan_ok = (c != 8'h00) && (c <= `MAX_CHANNEL);
   endfunction

   wire       link_dn = I_COMM_LOST | I_MASTER_STOP;
   wire       commit  = I_WR && (I_ADDR == `OFS_COMMIT);
   wire       busy    = (state != ST_IDLE) | start_req;
   wire       start   = commit & dirty & ~busy & ~link_dn;
   wire [7:0] jtype   = work[0];
   wire [4:0] ptr1    = ptr + 5'h01;
   wire [4:0] ptr2    = ptr + 5'h02;
   wire [4:0] ptr3    = ptr + 5'h03;
   wire [7:0] ea      = work[ptr];
   wire [7:0] eb      = work[ptr1];
   wire [7:0] ec      = work[ptr2];
   wire [7:0] ed      = work[ptr3];
   wire [3:0] gidx    = ea[3:0] - 4'h1;
   wire [7:0] cidx    = ea - 8'h01;
   wire [4:0] esize   = (jtype == `JOB_ASSIGN) ? 5'h04 : 5'h02;
   wire [8:0] fill_nx = {1'b0, fill_ch} + {7'h00, fill_step};

   // Staging area; a change marks the buffer as new data
   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         for (j = 0; j < 32; j = j + 1)
            stage[j] <= 8'h00;
         dirty <= 1'b0;
      end else if (I_WR && (I_ADDR < `OFS_INBUF)) begin
         stage[I_ADDR[4:0]] <= I_WDATA;
         if (stage[I_ADDR[4:0]] != I_WDATA)
            dirty <= 1'b1;
      end else if (start) begin
         dirty <= 1'b0;
      end
   end

   // Whole-buffer copy on commit, so the job is seen as one unit
   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         for (n = 0; n < 32; n = n + 1)
            work[n] <= 8'h00;
      end else if (start) begin
         for (n = 0; n < 32; n = n + 1)
            work[n] <= stage[n];
      end
   end

   // Job interpreter and configuration store
   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         state         <= ST_IDLE;
         start_req     <= 1'b1;
         link_prev     <= 1'b0;
         err           <= `ERR_OK;
         ptr           <= `HDR_BYTES;
         ent_left      <= 4'h0;
         fill_ch       <= 8'h00;
         fill_end      <= 8'h00;
         fill_step     <= 2'h1;
         fill_grp      <= 5'h00;
         grp_def       <= 16'h0000;
         test_on       <= 16'h0000;
         grp_cnt       <= 5'h00;
         O_ASSIGN_DONE <= 1'b0;
         for (k = 0; k < 4; k = k + 1)
            inbuf[k] <= 8'h00;
         for (k = 0; k < `GROUP_COUNT; k = k + 1)
            ovr[k] <= 7'h00;
         for (k = 0; k < `CHAN_COUNT; k = k + 1) begin
            chan_grp[k] <= 5'h00;
            base[k]     <= 7'h00;
         end
      end else begin
         link_prev <= link_dn;
         if (link_dn != link_prev) begin
            // Loss or return of the master restarts configuration
            start_req <= 1'b1;
            state     <= ST_IDLE;
         end else if (start_req) begin
            // Wipe config; no group checked after init
            start_req     <= 1'b0;
            grp_def       <= 16'h0000;
            test_on       <= 16'h0000;
            grp_cnt       <= 5'h00;
            O_ASSIGN_DONE <= 1'b0;
            for (k = 0; k < `GROUP_COUNT; k = k + 1)
               ovr[k] <= 7'h00;
            for (k = 0; k < `CHAN_COUNT; k = k + 1) begin
               chan_grp[k] <= 5'h00;
               base[k]     <= 7'h00;
            end
            inbuf[0] <= `JOB_STARTUP;
            inbuf[1] <= I_LINE_FREQ;
            inbuf[2] <= ~I_SLOT_PRESENT[7:0];
            inbuf[3] <= {`UNUSED_SLOTS, ~I_SLOT_PRESENT[11:8]};
         end else begin
            case (state)
               ST_IDLE: begin
                  if (start) begin
                     err   <= `ERR_OK;
                     state <= ST_HDR;
                  end
               end
               ST_HDR: begin
                  ptr      <= `HDR_BYTES;
                  ent_left <= (jtype == `JOB_ASSIGN) ?
                              {1'b0, work[1][4:2]} : work[1][4:1];
                  state    <= ST_ACK;
                  if (jtype > `JOB_TEST)
                     err <= `ERR_TYPE;
                  else if (work[1] > `MAX_NET_LEN)
                     err <= `ERR_LENGTH;
                  else if (jtype == `JOB_ASSIGN && O_ASSIGN_DONE)
                     err <= `ERR_ORDER;
                  else if (jtype != `JOB_NONE && jtype != `JOB_ASSIGN &&
                           !O_ASSIGN_DONE)
                     err <= `ERR_ORDER;
                  else if (jtype != `JOB_NONE)
                     state <= ST_ENT;
               end
               ST_ENT: begin
                  if (ent_left == 4'h0) begin
                     state <= ST_ACK;
                  end else begin
                     ptr      <= ptr + esize;
                     ent_left <= ent_left - 4'h1;
                     case (jtype)
                        `JOB_ASSIGN: begin
                           if (!grp_ok(ea)) begin
                              err <= `ERR_GROUP;
                              state <= ST_ACK;
                           end else if (eb > 8'h01) begin
                              err <= `ERR_GTYPE;
                              state <= ST_ACK;
                           end else if (!chan_ok(ec) || !chan_ok(ed) ||
                                        ec > ed) begin
                              err <= `ERR_CHANNEL;
                              state <= ST_ACK;
                           end else if (grp_cnt >= MAX_GROUPS) begin
                              err <= `ERR_GROUPFULL;
                              state <= ST_ACK;
                           end else if (grp_def[gidx]) begin
                              err <= `ERR_CHANLIST;
                              state <= ST_ACK;
                           end else begin
                              grp_def[gidx] <= 1'b1;
                              grp_cnt   <= grp_cnt + 5'h01;
                              fill_grp  <= ea[4:0];
                              fill_ch   <= ec - 8'h01;
                              fill_end  <= ed - 8'h01;
                              fill_step <= eb[0] ? 2'h2 : 2'h1;
                              state     <= ST_FILL;
                           end
                        end
                        `JOB_BASIC: begin
                           state <= ST_ACK;
                           if (!chan_ok(ea))
                              err <= `ERR_CHANNEL;
                           else if (eb > `MAX_PERCENT)
                              err <= `ERR_BASIC;
                           else if (chan_grp[cidx] == 5'h00)
                              err <= `ERR_NOCHGRP;
                           else begin
                              base[cidx] <= eb[6:0];
                              state      <= ST_ENT;
                           end
                        end
                        `JOB_OVERRIDE: begin
                           state <= ST_ACK;
                           if (!grp_ok(ea))
                              err <= `ERR_GROUP;
                           else if (eb > `MAX_PERCENT)
                              err <= `ERR_OVERRIDE;
                           else if (!grp_def[gidx])
                              err <= `ERR_NOGROUP;
                           else begin
                              ovr[gidx] <= eb[6:0];
                              state     <= ST_ENT;
                           end
                        end
                        default: begin
                           state <= ST_ACK;
                           if (!grp_ok(ea))
                              err <= `ERR_GROUP;
                           else if (eb > 8'h01)
                              err <= `ERR_TESTCMD;
                           else if (!grp_def[gidx])
                              err <= `ERR_NOGROUP;
                           else begin
                              test_on[gidx] <= eb[0];
                              state         <= ST_ENT;
                           end
                        end
                     endcase
                  end
               end
               ST_FILL: begin
                  // One channel per cycle; a taken channel is a clash
                  if (chan_grp[fill_ch] != 5'h00) begin
                     err   <= `ERR_CHANLIST;
                     state <= ST_ACK;
                  end else begin
                     chan_grp[fill_ch] <= fill_grp;
                     if (fill_nx > {1'b0, fill_end})
                        state <= ST_ENT;
                     else
                        fill_ch <= fill_nx[7:0];
                  end
               end
               ST_ACK: begin
                  // All four bytes change in the same edge
                  inbuf[0] <= jtype | ((err != `ERR_OK) ?
                              `FAIL_BIT : 8'h00);
                  inbuf[1] <= `ACK_MARK;
                  inbuf[2] <= (err != `ERR_OK) ? err : work[2];
                  inbuf[3] <= work[3];
                  if (jtype == `JOB_ASSIGN && err == `ERR_OK &&
                      work[2] == work[3])
                     O_ASSIGN_DONE <= 1'b1;
                  state <= ST_IDLE;
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Register read port: data in the cycle after the strobe only
   always @(posedge I_CLK_SYS) begin
      if (I_SRST || !I_RD)
         O_RDATA <= 8'h00;
      else if (I_ADDR < `OFS_INBUF)
         O_RDATA <= stage[I_ADDR[4:0]];
      else if (I_ADDR < `OFS_COMMIT)
         O_RDATA <= inbuf[I_ADDR[1:0]];
      else if (I_ADDR == `OFS_STATUS)
         O_RDATA <= {busy, O_ASSIGN_DONE, dirty, grp_cnt};
      else
         O_RDATA <= 8'h00;
   end

   // Round-robin scan of all channels towards the output stage
   always @(posedge I_CLK_SYS) begin
      if (I_SRST || scan == `MAX_CHANNEL - 8'h01)
         scan <= 8'h00;
      else
         scan <= scan + 8'h01;
   end

   wire [4:0] s_grp  = chan_grp[scan];
   wire [3:0] s_gi   = s_grp[3:0] - 4'h1;
   // Slot of a channel is its index over sixteen
   wire       s_slot = I_SLOT_PRESENT[scan[7:4]];
   wire       s_on   = (s_grp != 5'h00) & s_slot & ~link_dn;

   power_scale u_scale (
      .clk     (I_CLK_SYS),
      .srst    (I_SRST),
      .i_valid (1'b1),
      .i_chan  (scan + 8'h01),
      .i_base  (base[scan]),
      .i_ovr   (ovr[s_gi]),
      .i_on    (s_on),
      .i_check (test_on[s_gi]),
      .o_valid (O_CHAN_VALID),
      .o_chan  (O_CHAN_NUM),
      .o_power (O_CHAN_POWER),
      .o_check (O_CHAN_CHECK)
   );

endmodule // heater_job

// *** rtl/heater_job_map.vh ***
// Constants of the heater job interpreter: register offsets, job and
// error codes, frame layout and limits.
// Assumes inclusion by plain Verilog-2005 design files only.
`ifndef HEATER_JOB_MAP_VH
`define HEATER_JOB_MAP_VH

// Register offsets (byte wide, 6-bit address)
`define OFS_OUTBUF     6'h00
`define OFS_INBUF      6'h20
`define OFS_COMMIT     6'h24
`define OFS_STATUS     6'h25

// Job types
`define JOB_NONE       8'h00
`define JOB_ASSIGN     8'h01
`define JOB_BASIC      8'h02
`define JOB_OVERRIDE   8'h03
`define JOB_TEST       8'h04
`define JOB_STARTUP    8'h05

// Error numbers
`define ERR_OK         8'h00
`define ERR_ALLOC      8'h01
`define ERR_ORDER      8'h02
`define ERR_TYPE       8'h03
`define ERR_LENGTH     8'h04
`define ERR_GROUP      8'h05
`define ERR_CHANNEL    8'h06
`define ERR_GTYPE      8'h07
`define ERR_TESTCMD    8'h08
`define ERR_OVERRIDE   8'h09
`define ERR_BASIC      8'h0a
`define ERR_GROUPFULL  8'h0b
`define ERR_NOCHGRP    8'h0c
`define ERR_NOGROUP    8'h0d
`define ERR_CHANLIST   8'h0e

// Frame layout and limits
`define HDR_BYTES      5'h04
`define MAX_NET_LEN    8'h1c
`define MAX_PERCENT    8'h64
`define MAX_CHANNEL    8'hc0
`define MAX_GROUP      8'h10
`define ACK_MARK       8'h01
`define FAIL_BIT       8'h80
`define UNUSED_SLOTS   4'hf
`define SLOT_COUNT     12
`define CHAN_COUNT     192
`define GROUP_COUNT    16

`endif

// *** rtl/power_scale.v ***
// Output value stage: basic percent times override percent of the owning
// group, scaled back to percent, registered.
// Assumes the caller presents one channel per cycle from its scan.
`timescale 1ns/1ps
module power_scale (
   input  wire       clk,
   input  wire       srst,
   input  wire       i_valid,
   input  wire [7:0] i_chan,
   input  wire [6:0] i_base,
   input  wire [6:0] i_ovr,
   input  wire       i_on,
   input  wire       i_check,
   output reg        o_valid,
   output reg  [7:0] o_chan,
   output reg  [6:0] o_power,
   output reg        o_check
);

   wire [13:0] product = i_base * i_ovr;
   wire [13:0] quot    = product / 14'h0064;

   // Channel value: base x override / 100
   always @(posedge clk) begin
      if (srst) begin
         o_valid <= 1'b0;
         o_chan  <= 8'h00;
         o_power <= 7'h00;
         o_check <= 1'b0;
      end else begin
         o_valid <= i_valid;
         o_chan  <= i_chan;
         o_power <= i_on ? quot[6:0] : 7'h00;
         o_check <= i_on & i_check;
      end
   end

endmodule // power_scale

// *** test/fieldbus_master_model.sv ***
// Fieldbus master model: places jobs in the output buffer over the byte
// register port, sets the job bit and polls until the device is idle.
// Assumes one rising-edge clock shared with the device.
`timescale 1ns/1ps
module fieldbus_master_model (
   input  wire       i_clk,
   input  wire [7:0] i_rdata,
   output reg  [5:0] o_addr,
   output reg  [7:0] o_wdata,
   output reg        o_wr,
   output reg        o_rd
);
   initial begin
      o_addr = 6'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // Write strobe stays up for back-to-back writes; a read lowers it
   task wr(input [5:0] a, input [7:0] d);
      begin
         o_addr <= a;
         o_wdata <= d;
         o_wr <= 1'b1;
         @(posedge i_clk);
      end
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input [5:0] a, output [7:0] d);
      begin
         o_wr <= 1'b0;
         o_addr <= a;
         o_rd <= 1'b1;
         @(posedge i_clk);
         o_rd <= 1'b0;
         @(negedge i_clk);
         d = i_rdata;
         @(posedge i_clk);
      end
   endtask

   // Header and data first, job bit last, then wait while busy
   task post(input [7:0] t, l, b2, b3, input [63:0] d);
      integer k;
      reg [7:0] s;
      begin
         wr(6'h00, t);
         wr(6'h01, l);
         wr(6'h02, b2);
         wr(6'h03, b3);
         for (k = 0; k < 8; k = k + 1)
            wr(6'h04 + k[5:0], d[63-8*k -: 8]);
         wr(6'h24, 8'h01);
         s = 8'h80;
         for (k = 0; k < 200 && s[7]; k = k + 1)
            rd(6'h25, s);
      end
   endtask
endmodule // fieldbus_master_model

// *** test/heater_job_properties.sv ***
// Port checks of the heater job interpreter: read answer, channel scan
// and output gating.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module heater_job_properties #(
   parameter [4:0] MAX_GROUPS = 5'h10
) (
   input wire        I_CLK_SYS,
   input wire        I_SRST,
   input wire        I_RD,
   input wire [7:0]  O_RDATA,
   input wire [11:0] I_SLOT_PRESENT,
   input wire        I_COMM_LOST,
   input wire        I_MASTER_STOP,
   input wire        O_ASSIGN_DONE,
   input wire        O_CHAN_VALID,
   input wire [7:0]  O_CHAN_NUM,
   input wire [6:0]  O_CHAN_POWER
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_SRST);

   // Slot of the channel on show; channels 1-16 sit in slot 1
   wire [7:0] num_m1 = O_CHAN_NUM - 8'h01;
   wire       link_down = I_COMM_LOST | I_MASTER_STOP;

   AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data not zero outside a read answer");
   AST_POWER_MAX: assert property (O_CHAN_VALID |-> O_CHAN_POWER <= 7'h64)
      else $error("channel power above full scale");
   AST_CHAN_RANGE: assert property (O_CHAN_VALID |->
      O_CHAN_NUM inside {[8'h01:8'hc0]}) else $error("channel out of range");
   AST_SCAN_STEP: assert property (O_CHAN_VALID && $past(O_CHAN_VALID) &&
      $past(O_CHAN_NUM) != 8'hc0 |-> O_CHAN_NUM == $past(O_CHAN_NUM) + 8'h01)
      else $error("channel scan skipped");
   AST_SCAN_WRAP: assert property ($past(O_CHAN_VALID) &&
      $past(O_CHAN_NUM) == 8'hc0 |-> O_CHAN_NUM == 8'h01)
      else $error("channel scan did not wrap");
   AST_SLOT_ABSENT: assert property (O_CHAN_VALID &&
      !I_SLOT_PRESENT[num_m1[7:4]] |-> O_CHAN_POWER == 7'h00)
      else $error("power on absent slot");
   AST_LINK_DOWN_OFF: assert property (link_down[*3] |->
      O_CHAN_POWER == 7'h00) else $error("power while link down");
   AST_IDLE_OFF: assert property ((!O_ASSIGN_DONE)[*3] |->
      O_CHAN_POWER == 7'h00) else $error("power before assignment");
   AST_DONE_WIPED: assert property ($changed(link_down) |->
      ##[1:3] !O_ASSIGN_DONE) else $error("assignment kept over link change");

   COV_DONE: cover property ($rose(O_ASSIGN_DONE));
   COV_POWER: cover property (O_CHAN_VALID && O_CHAN_POWER != 7'h00);
   COV_LINK: cover property ($rose(link_down));
endmodule // heater_job_properties

bind heater_job heater_job_properties #(.MAX_GROUPS(MAX_GROUPS)) i_props (
   .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .I_SLOT_PRESENT(I_SLOT_PRESENT), .I_COMM_LOST(I_COMM_LOST),
   .I_MASTER_STOP(I_MASTER_STOP), .O_ASSIGN_DONE(O_ASSIGN_DONE),
   .O_CHAN_VALID(O_CHAN_VALID), .O_CHAN_NUM(O_CHAN_NUM),
   .O_CHAN_POWER(O_CHAN_POWER)
);

// *** test/tb_heater_job.sv ***
// Self-checking bench of the heater job interpreter: jobs placed through
// the master model, acknowledgments and channel outputs compared.
// Assumes the master model and checker files are compiled before it.
`timescale 1ns/1ps
module tb_heater_job;
   reg         clk;
   reg         srst;
   reg  [7:0]  freq;
   reg         lost;
   reg         stop;
   wire [5:0]  addr;
   wire [7:0]  wdata;
   wire        wr;
   wire        rd;
   wire [7:0]  rdata;
   wire        done;
   wire [7:0]  cnum;
   wire [6:0]  cpow;
   wire        cchk;
   wire        cval;
   reg  [11:0] slots;
   integer     failures;
   integer     comparisons;
   integer     cycles;
   integer     i;
   reg  [7:0]  seq;
   reg  [7:0]  v;
   reg  [7:0]  f [0:2];

   // Two groups only, so the full-table case is cheap to reach
   heater_job #(.MAX_GROUPS(5'h02)) i_dut (
      .I_CLK_SYS(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_LINE_FREQ(freq),
      .I_SLOT_PRESENT(slots), .I_COMM_LOST(lost), .I_MASTER_STOP(stop),
      .O_ASSIGN_DONE(done), .O_CHAN_VALID(cval), .O_CHAN_NUM(cnum),
      .O_CHAN_POWER(cpow), .O_CHAN_CHECK(cchk)
   );
   fieldbus_master_model i_master (
      .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd)
   );

   initial clk = 1'b0;
   always #50 clk = ~clk;

   task test_done;
      begin
         if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // Hang guard well above the one thousand or so cycles the run needs
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         test_done;
      end
   end

   task check(input string name, input [7:0] seen, exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   task inbuf(input [7:0] e0, e1, e2, e3);
      reg [31:0] e;
      integer k;
      begin
         e = {e0, e1, e2, e3};
         for (k = 0; k < 4; k = k + 1) begin
            i_master.rd(6'h20 + k[5:0], v);
            check("input buffer byte", v, e[31-8*k -: 8]);
         end
      end
   endtask

   // c set: block number equals block count
   task job(input [7:0] t, l, input c, input [63:0] d, input [7:0] err);
      reg [7:0] b2;
      begin
         seq = seq + 8'h01;
         b2 = c ? seq : 8'h00;
         i_master.post(t, l, b2, seq, d);
         inbuf(err != 8'h00 ? (t | 8'h80) : t, 8'h01,
               err != 8'h00 ? err : b2, seq);
      end
   endtask

   // Outputs sampled mid-cycle while channel 1 is on show
   task at_ch1(input [7:0] pw, input ck);
      integer k;
      begin
         k = 0;
         @(negedge clk);
         while (cnum !== 8'h01 && k < 400) begin
            @(negedge clk);
            k = k + 1;
         end
         check("channel number", cnum, 8'h01);
         check("channel valid", {7'h00, cval}, 8'h01);
         check("channel power", {1'b0, cpow}, pw);
         check("channel check", {7'h00, cchk}, {7'h00, ck});
         @(posedge clk);
      end
   endtask

   initial begin
      failures = 0;
      comparisons = 0;
      cycles = 0;
      seq = 8'h00;
      srst = 1'b1;
      freq = 8'h32;
      slots = 12'h5a1;
      lost = 1'b0;
      stop = 1'b0;
      f[0] = 8'h32;
      f[1] = 8'h3c;
      f[2] = 8'h00;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      inbuf(8'h05, 8'h32, 8'h5e, 8'hfa);
      job(8'h02, 8'h02, 1'b1, {16'h0132, 48'h0}, 8'h02);
      job(8'h06, 8'h00, 1'b0, 64'h0, 8'h03);
      job(8'h05, 8'h00, 1'b0, 64'h0, 8'h03);
      job(8'h01, 8'h1d, 1'b0, 64'h0, 8'h04);
      job(8'h01, 8'h04, 1'b0, {32'h11000110, 32'h0}, 8'h05);
      job(8'h01, 8'h04, 1'b0, {32'h01020110, 32'h0}, 8'h07);
      job(8'h01, 8'h04, 1'b0, {32'h010001c1, 32'h0}, 8'h06);
      job(8'h01, 8'h08, 1'b0, 64'h0100011001002130, 8'h0e);
      job(8'h01, 8'h08, 1'b0, 64'h0201111f03002130, 8'h0b);
      check("assignment done", {7'h00, done}, 8'h00);
      job(8'h01, 8'h00, 1'b1, 64'h0, 8'h00);
      check("assignment done", {7'h00, done}, 8'h01);
      job(8'h01, 8'h04, 1'b1, {32'h01000110, 32'h0}, 8'h02);
      job(8'h02, 8'h04, 1'b0, {32'h01321232, 32'h0}, 8'h0c);
      job(8'h02, 8'h02, 1'b0, {16'hc910, 48'h0}, 8'h06);
      job(8'h02, 8'h02, 1'b0, {16'h0165, 48'h0}, 8'h0a);
      job(8'h03, 8'h02, 1'b0, {16'h0165, 48'h0}, 8'h09);
      job(8'h03, 8'h02, 1'b0, {16'h0532, 48'h0}, 8'h0d);
      job(8'h03, 8'h02, 1'b0, {16'h1132, 48'h0}, 8'h05);
      job(8'h03, 8'h02, 1'b1, {16'h0132, 48'h0}, 8'h00);
      at_ch1(8'h19, 1'b0);
      job(8'h04, 8'h02, 1'b0, {16'h0102, 48'h0}, 8'h08);
      job(8'h04, 8'h02, 1'b1, {16'h0101, 48'h0}, 8'h00);
      at_ch1(8'h19, 1'b1);
      job(8'h04, 8'h02, 1'b1, {16'h0100, 48'h0}, 8'h00);
      at_ch1(8'h19, 1'b0);
      job(8'h00, 8'h00, 1'b1, 64'h0, 8'h00);
      i_master.wr(6'h24, 8'h01);
      inbuf(8'h00, 8'h01, seq, seq);
      // Each link break and resumption must rebuild the startup frame
      for (i = 0; i < 3; i = i + 1) begin
         freq <= f[i];
         // Slot 1 kept present so channel 1 power stays legal
         slots <= slots ^ 12'h3c6;
         lost <= (i == 0);
         stop <= (i != 0);
         repeat (4) @(posedge clk);
         lost <= 1'b0;
         stop <= 1'b0;
         repeat (4) @(posedge clk);
         inbuf(8'h05, f[i], ~slots[7:0], {4'hf, ~slots[11:8]});
      end
      check("assignment done", {7'h00, done}, 8'h00);
      job(8'h03, 8'h02, 1'b1, {16'h0132, 48'h0}, 8'h02);
      test_done;
   end
endmodule // tb_heater_job
